// ===== rtl/isc_regs.vh
/*
 * Register map, field positions, reset values and threshold constants of
 * the interrupt status collector.
 * Assumes a 32-bit APB slave with each register taking one aligned word.
 */
`ifndef ISC_REGS_VH
`define ISC_REGS_VH
// ============================================================
// Overview of operation
// R01: 32-bit status; host writes ones to acknowledge, exactly those bits clear.
// R02: Bit 31 sets when software event enable goes from low to high; write one clears.
// R03: Bit 25 sets when transmit stop requested and transmitter halted.
// R04: Bit 24 sets when the receiver has halted.
// R05: Bit 23 sets when drop counter goes 7FFFFFFFh to 80000000h.
// R06: Bit 21 sets when an interrupt-on-completion buffer fully loaded.
// R07: Bit 20 sets when programmed receive transfer count has been read.
// R08: Bit 19 sets when general-purpose timer wraps past zero to FFFFh.
// R09: Bit 18 read-only, follows physical layer event; writes do nothing.
// R10: Bit 17 sets on power event, independent of pin; write one clears.
// R11: Power event does not wake; only a write to byte test wakes.
// R12: Power event interrupt bypasses the deassertion interval hold-off.
// R13: Bit 16 sets when the transmit status FIFO overflows.
// R14: Bit 15 sets when a received packet exceeds 2048 bytes.
// R15: Bit 14 on receiver error; bit 13 on transmitter error.
// R16: Bit 10 sets on host write while transmit data FIFO full.
// R17: Bit 9 sets when transmit free space exceeds available level.
// R18: Bit 8 on transmit status full; bit 4 on receive status full.
// R19: Bit 7 transmit status level exceeded; bit 3 receive status level exceeded.
// R20: Bit 6 sets every time a received frame is dropped.
// R21: Bits 2-0 latch events of the three configured I/O lines.
// R22: Status bits record events regardless of the enable mask.
// R23: Master indication bit 12 high when any enabled status bit active.
// R24: Available level in 64-byte blocks; status levels in 32-bit words.
// R25: Flags stay until cleared; zero writes keep; reserved reads zero.
// ============================================================
// Register byte addresses.
`define ISC_ADDR_W          8
`define ISC_OFS_IRQ_CFG     8'h54
`define ISC_OFS_INTERRUPT_STATUS     8'h58
`define ISC_OFS_INT_EN      8'h5C
`define ISC_OFS_BYTE_TEST   8'h64
`define ISC_OFS_FIFO_INT    8'h68
`define ISC_OFS_RX_CFG      8'h6C
`define ISC_OFS_GPT_CNT     8'h90
`define ISC_OFS_RX_DROP     8'hA0
`define ISC_OFS_EVT_CTRL    8'hC0
// ============================================================
// Status bit positions.
`define ISC_B_SW            31
`define ISC_B_TXSTOP        25
`define ISC_B_RXSTOP        24
`define ISC_B_DROPH         23
`define ISC_B_TXDONE        21
`define ISC_B_RXDMA         20
`define ISC_B_TIMER         19
`define ISC_B_PHY           18
`define ISC_B_PWR           17
`define ISC_B_TSOVF         16
`define ISC_B_RWDOG         15
`define ISC_B_RXERR         14
`define ISC_B_TXERR         13
`define ISC_B_TDOVR         10
`define ISC_B_TDAVL         9
`define ISC_B_TSFULL        8
`define ISC_B_TSLVL         7
`define ISC_B_RXDROP        6
`define ISC_B_RSFULL        4
`define ISC_B_RSLVL         3
`define ISC_B_IO_HI         2
// Implemented status and enable bits; all others read zero.
`define ISC_STS_MASK        32'h83BFE7DF
// Interrupt configuration fields.
`define ISC_B_MASTER        12
`define ISC_B_IRQ_EN        8
`define ISC_B_SWEN          31
// Threshold register fields and reset value.
`define ISC_FI_RESET        32'h48000000
// Writable threshold fields; the middle byte is reserved and reads zero.
`define ISC_FI_MASK         32'hFFFF00FF
`define ISC_FI_TDA_HI       31
`define ISC_FI_TDA_LO       24
`define ISC_FI_TSL_HI       23
`define ISC_FI_TSL_LO       16
`define ISC_FI_RSL_HI       7
`define ISC_FI_RSL_LO       0
`define ISC_BLK_SHIFT       4
// Receive transfer count field.
`define ISC_RXC_HI          27
`define ISC_RXC_LO          16
`define ISC_RXC_W           12
// Constants for counters and identity.
`define ISC_BYTE_TEST_VAL   32'h87654321
`define ISC_DROP_HALF_FROM  32'h7FFFFFFF
`define ISC_TIMER_MAX       16'hFFFF
`define ISC_RWDOG_BYTES     12'h800
`define ISC_EVT_STOP_TX     0
`endif

// ===== rtl/isc_w1c_bit.v
/*
 * One sticky status flag: set by a hardware event, cleared by a write of
 * one from the host. Set wins over a clear in the same cycle.
 * Assumes all inputs synchronous to clk_sys.
 */
`timescale 1ns/100ps
`default_nettype none
module isc_w1c_bit (
  // Clock, reset and enable.
  input  wire clk_sys,
  input  wire resetn,
  input  wire ce,
  // Event and clear.
  input  wire set_evt,
  input  wire clr_wr,
  // Flag.
  output reg  flag_q
);
  // ============================================================
  // Sticky flag with set priority.
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      flag_q <= 1'b0;
    end else if (ce) begin
      if (set_evt) begin
        flag_q <= 1'b1; // R01
      end else if (clr_wr) begin
        flag_q <= 1'b0; // R25
      end
    end
  end
endmodule
`default_nettype wire

// ===== rtl/isc_edge.v
/*
 * Rising-edge detector for one event level.
 * Assumes the level is synchronous to clk_sys.
 */
`timescale 1ns/100ps
`default_nettype none
module isc_edge (
  // Clock, reset and enable.
  input  wire clk_sys,
  input  wire resetn,
  input  wire ce,
  // Level in, pulse out.
  input  wire level,
  output wire rise
);
  reg level_q;
  // ============================================================
  // Previous sample of the level.
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      level_q <= 1'b0;
    end else if (ce) begin
      level_q <= level;
    end
  end
  assign rise = level & ~level_q;
endmodule
`default_nettype wire

// ===== rtl/isc_top.v
/*
 * Interrupt status collector: gathers the event sources of an Ethernet
 * controller into a sticky status register with write-one-to-clear, an
 * enable mask, a master indication, thresholds and a few counters that
 * produce event pulses, all reached over APB.
 * Assumes source units drive synchronous event pulses and levels.
 */
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "isc_regs.vh"
module isc_top (
  // Clock, reset and enable.
  input  wire        clk_sys,
  input  wire        resetn,
  input  wire        ce,
  // APB slave.
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Transmit side events.
  input  wire        tx_halted,
  input  wire        tx_buf_loaded_ioc,
  input  wire        tx_status_push,
  input  wire        tx_status_full,
  input  wire [7:0]  tx_status_used,
  input  wire [7:0]  tx_data_free_blocks,
  input  wire        tx_data_write,
  input  wire        tx_data_full,
  input  wire        tx_error,
  // Receive side events.
  input  wire        rx_halted,
  input  wire        rx_data_pop,
  input  wire        rx_frame_dropped,
  input  wire        rx_byte,
  input  wire        rx_frame_end,
  input  wire        rx_status_full,
  input  wire [7:0]  rx_status_used,
  input  wire        rx_error,
  // Other sources.
  input  wire        timer_tick,
  input  wire        phy_event,
  input  wire        power_event,
  input  wire [2:0]  io_line_events,
  // Outputs.
  output wire        irq_line,
  output wire        power_irq,
  output reg         wake_q,
  output wire        stop_tx_req
);
  // ============================================================
  // Registers.
  reg  [31:0] int_en_q;
  reg  [31:0] fifo_int_q;
  reg         irq_en_q;
  reg         sw_enable_q;
  reg         stop_tx_q;
  reg  [11:0] rx_count_q;
  reg         rx_count_live_q;
  reg  [15:0] timer_q;
  reg  [31:0] drop_q;
  reg  [11:0] rx_len_q;
  reg         rwdog_hit_q;
  wire [31:0] sts;
  wire [31:0] set_vec;
  wire        acc;
  wire        wr;
  wire        sts_wr;
  wire        pw_irq;

  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign acc     = psel & penable;
  assign wr      = acc & pwrite & ce;
  assign sts_wr  = wr & (paddr == `ISC_OFS_INTERRUPT_STATUS);
  assign stop_tx_req = stop_tx_q;

  // ============================================================
  // Level sources turned into set pulses at their rising edge.
  wire [7:0] lvl_in;
  wire [7:0] lvl_rise;
  assign lvl_in[0] = sw_enable_q;
  assign lvl_in[1] = stop_tx_q & tx_halted;
  assign lvl_in[2] = rx_halted;
  assign lvl_in[3] = tx_status_full;
  assign lvl_in[4] = rx_status_full;
  assign lvl_in[5] = tx_data_free_blocks >
                     fifo_int_q[`ISC_FI_TDA_HI:`ISC_FI_TDA_LO];
  assign lvl_in[6] = tx_status_used >
                     fifo_int_q[`ISC_FI_TSL_HI:`ISC_FI_TSL_LO];
  assign lvl_in[7] = rx_status_used >
                     fifo_int_q[`ISC_FI_RSL_HI:`ISC_FI_RSL_LO];
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_edge
      isc_edge u_edge (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .ce      (ce),
        .level   (lvl_in[g]),
        .rise    (lvl_rise[g])
      );
    end
  endgenerate

  // ============================================================
  // Set vector: each bit names the event that latches it.
  wire rx_count_done;
  wire timer_wrap;
  wire drop_half;
  assign rx_count_done = rx_count_live_q & rx_data_pop &
                         (rx_count_q == {{(`ISC_RXC_W-1){1'b0}}, 1'b1});
  assign timer_wrap = timer_tick & (timer_q == 16'h0000);
  assign drop_half  = rx_frame_dropped & (drop_q == `ISC_DROP_HALF_FROM);
  assign set_vec[`ISC_B_SW]     = lvl_rise[0];              // R02
  assign set_vec[30:26]         = 5'h00;
  assign set_vec[`ISC_B_TXSTOP] = lvl_rise[1];              // R03
  assign set_vec[`ISC_B_RXSTOP] = lvl_rise[2];              // R04
  assign set_vec[`ISC_B_DROPH]  = drop_half;                // R05
  assign set_vec[22]            = 1'b0;
  assign set_vec[`ISC_B_TXDONE] = tx_buf_loaded_ioc;        // R06
  assign set_vec[`ISC_B_RXDMA]  = rx_count_done;            // R07
  assign set_vec[`ISC_B_TIMER]  = timer_wrap;               // R08
  assign set_vec[`ISC_B_PHY]    = 1'b0;
  assign set_vec[`ISC_B_PWR]    = power_event;              // R10
  assign set_vec[`ISC_B_TSOVF]  = tx_status_push & tx_status_full; // R13
  assign set_vec[`ISC_B_RWDOG]  = rwdog_hit_q;              // R14
  assign set_vec[`ISC_B_RXERR]  = rx_error;                 // R15
  assign set_vec[`ISC_B_TXERR]  = tx_error;                 // R15
  assign set_vec[12:11]         = 2'b00;
  assign set_vec[`ISC_B_TDOVR]  = tx_data_write & tx_data_full; // R16
  assign set_vec[`ISC_B_TDAVL]  = lvl_rise[5];              // R17 R24
  assign set_vec[`ISC_B_TSFULL] = lvl_rise[3];              // R18
  assign set_vec[`ISC_B_TSLVL]  = lvl_rise[6];              // R19 R24
  assign set_vec[`ISC_B_RXDROP] = rx_frame_dropped;         // R20
  assign set_vec[5]             = 1'b0;
  assign set_vec[`ISC_B_RSFULL] = lvl_rise[4];              // R18
  assign set_vec[`ISC_B_RSLVL]  = lvl_rise[7];              // R19 R24
  assign set_vec[`ISC_B_IO_HI:0] = io_line_events;          // R21

  // ============================================================
  // Sticky flags except read-only bit 18; set regardless of the mask, only implemented bits.
  genvar b;
  generate
    for (b = 0; b < 32; b = b + 1) begin : g_sts
      if (b == `ISC_B_PHY) begin : g_ro
        assign sts[b] = phy_event; // R09
      end else if (((`ISC_STS_MASK >> b) & 1) == 1) begin : g_w1c
        isc_w1c_bit u_bit (
          .clk_sys (clk_sys),
          .resetn  (resetn),
          .ce      (ce),
          .set_evt (set_vec[b]),         // R22
          .clr_wr  (sts_wr & pwdata[b]), // R01
          .flag_q  (sts[b])
        );
      end else begin : g_rsv
        assign sts[b] = 1'b0; // R25
      end
    end
  endgenerate

  // ============================================================
  // Master indication and interrupt outputs.
  wire master;
  assign master    = |(sts & int_en_q);                          // R23
  assign irq_line  = irq_en_q & master;
  assign pw_irq    = sts[`ISC_B_PWR] & int_en_q[`ISC_B_PWR];
  assign power_irq = irq_en_q & pw_irq; // R12

  // ============================================================
  // Software-written configuration registers.
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      int_en_q    <= 32'h00000000;
      fifo_int_q  <= `ISC_FI_RESET;
      irq_en_q    <= 1'b0;
      sw_enable_q <= 1'b0;
      stop_tx_q   <= 1'b0;
    end else if (wr) begin
      case (paddr)
        `ISC_OFS_INT_EN: begin
          int_en_q    <= pwdata & `ISC_STS_MASK;
          sw_enable_q <= pwdata[`ISC_B_SWEN];
        end
        `ISC_OFS_IRQ_CFG: begin
          irq_en_q <= pwdata[`ISC_B_IRQ_EN];
        end
        `ISC_OFS_FIFO_INT: begin
          fifo_int_q <= pwdata & `ISC_FI_MASK;
        end
        `ISC_OFS_EVT_CTRL: begin
          stop_tx_q <= pwdata[`ISC_EVT_STOP_TX];
        end
        default: begin
          irq_en_q <= irq_en_q;
        end
      endcase
    end
  end

  // ============================================================
  // Wake only on a host write to the byte test register.
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wake_q <= 1'b0;
    end else if (ce) begin
      wake_q <= wr & (paddr == `ISC_OFS_BYTE_TEST); // R11
    end
  end

  // ============================================================
  // Receive transfer count: loaded by host, counts down per word read.
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rx_count_q      <= {`ISC_RXC_W{1'b0}};
      rx_count_live_q <= 1'b0;
    end else if (ce) begin
      if (wr && paddr == `ISC_OFS_RX_CFG) begin
        rx_count_q      <= pwdata[`ISC_RXC_HI:`ISC_RXC_LO];
        rx_count_live_q <= |pwdata[`ISC_RXC_HI:`ISC_RXC_LO];
      end else if (rx_count_live_q && rx_data_pop) begin
        rx_count_q      <= rx_count_q - {{(`ISC_RXC_W-1){1'b0}}, 1'b1};
        rx_count_live_q <= ~rx_count_done; // R07
      end
    end
  end

  // ============================================================
  // General-purpose timer, drop counter and receive length watchdog.
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      timer_q     <= `ISC_TIMER_MAX;
      drop_q      <= 32'h00000000;
      rx_len_q    <= 12'h000;
      rwdog_hit_q <= 1'b0;
    end else if (ce) begin
      if (timer_tick) begin
        timer_q <= timer_wrap ? `ISC_TIMER_MAX : timer_q - 16'h0001; // R08
      end
      if (rx_frame_dropped) begin
        drop_q <= drop_q + 32'h00000001; // R05
      end
      rwdog_hit_q <= 1'b0;
      if (rx_frame_end) begin
        rx_len_q <= 12'h000;
      end else if (rx_byte && rx_len_q != `ISC_RWDOG_BYTES) begin
        rx_len_q <= rx_len_q + 12'h001;
      end else if (rx_byte) begin
        rwdog_hit_q <= 1'b1; // R14
      end
    end
  end

  // ============================================================
  // Read multiplexer; unmapped addresses read zero.
  always @* begin
    case (paddr)
      `ISC_OFS_INTERRUPT_STATUS:   prdata = sts;
      `ISC_OFS_INT_EN:    prdata = int_en_q;
      `ISC_OFS_IRQ_CFG:   prdata = {19'h00000, master, 3'h0, irq_en_q,
                                    8'h00}; // R23
      `ISC_OFS_BYTE_TEST: prdata = `ISC_BYTE_TEST_VAL;
      `ISC_OFS_FIFO_INT:  prdata = fifo_int_q;
      `ISC_OFS_RX_CFG:    prdata = {4'h0, rx_count_q, 16'h0000};
      `ISC_OFS_GPT_CNT:   prdata = {16'h0000, timer_q};
      `ISC_OFS_RX_DROP:   prdata = drop_q;
      `ISC_OFS_EVT_CTRL:  prdata = {31'h00000000, stop_tx_q};
      default:            prdata = 32'h00000000;
    endcase
  end
endmodule
`default_nettype wire

// ===== sim/isc_host.sv
/* APB host model: issues one word transfer at a time.
   Assumes a slave that may stretch the access phase with pready. */
`timescale 1ns/100ps
`default_nettype none
module isc_host (
  // Clock.
  input  wire logic        clk_sys,
  // APB master side.
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [7:0]  paddr,
  output var  logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready
);
  // ==================
  // Bus cycles
  // Idle bus from time zero.
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end

  // Setup, then access held until pready; a read returns prdata in d.
  task automatic xfer(input logic w, input logic [7:0] a,
                      inout logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    if (!w)
      d = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== sim/isc_props.sv
/* Checker of the interrupt status collector's port behaviour.
   Assumes it is bound to isc_top and sees only its ports. */
`timescale 1ns/100ps
`default_nettype none
`include "isc_regs.vh"
module isc_checker (
  // Clock, reset and enable.
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        ce,
  // APB.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // Sources and outputs.
  input wire logic        tx_error,
  input wire logic        rx_frame_dropped,
  input wire logic        power_event,
  input wire logic        phy_event,
  input wire logic        irq_line,
  input wire logic        power_irq,
  input wire logic        wake_q
);
  // ==================
  // Helpers
  localparam logic [31:0] resv = 32'h7C401820;
  logic rd_s;
  logic wr_s;
  logic wr_t;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Completed status read, status write and byte test write.
  assign rd_s = psel && penable && !pwrite && paddr == `ISC_OFS_INTERRUPT_STATUS;
  assign wr_s = psel && penable && pwrite && ce && paddr == `ISC_OFS_INTERRUPT_STATUS;
  assign wr_t = psel && penable && pwrite && ce &&
                paddr == `ISC_OFS_BYTE_TEST;

  // ==================
  // Assertions
  chk_phy_direct: assert property (rd_s |-> prdata[18] == phy_event)
    else $error("status bit 18 differs from phy input");
  chk_reserved_zero: assert property (rd_s |-> (prdata & resv) == 0)
    else $error("reserved status bit reads one");
  chk_power_path: assert property (power_irq |-> irq_line)
    else $error("power interrupt without irq line");
  chk_wake_cause: assert property (wake_q |-> $past(wr_t))
    else $error("wake without byte test write");
  chk_wake_follow: assert property (wr_t |=> wake_q)
    else $error("byte test write did not wake");
  chk_power_flag: assert property
    (power_event && ce ##3 rd_s |-> prdata[17])
    else $error("power event not recorded");
  chk_drop_flag: assert property
    (rx_frame_dropped && ce ##3 rd_s |-> prdata[6])
    else $error("dropped frame not recorded");
  chk_txerr_flag: assert property
    (tx_error && ce ##3 rd_s |-> prdata[13])
    else $error("transmit error not recorded");
  chk_clear_exact: assert property (wr_s && pwdata[6] &&
    !rx_frame_dropped ##1 !rx_frame_dropped [*2] ##1 rd_s |-> !prdata[6])
    else $error("written one did not clear flag");

  // Main scenarios reached.
  cover property (wake_q);
  cover property (power_irq);
  cover property (rd_s && prdata[19]);
endmodule

bind isc_top isc_checker i_chk (.clk_sys(clk_sys), .resetn(resetn),
  .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .tx_error(tx_error),
  .rx_frame_dropped(rx_frame_dropped), .power_event(power_event),
  .phy_event(phy_event), .irq_line(irq_line), .power_irq(power_irq),
  .wake_q(wake_q));
`default_nettype wire

// ===== sim/interrupt_status_collector_bench.sv
/* Self-checking bench of the interrupt status collector.
   Assumes rtl/ is on the include path and the host model drives APB. */
`timescale 1ns/100ps
`default_nettype none
`include "isc_regs.vh"
module interrupt_status_collector_bench;
  // ==================
  // Signals
  localparam logic [7:0] sts = `ISC_OFS_INTERRUPT_STATUS;
  localparam logic [7:0] ena = `ISC_OFS_INT_EN;
  localparam logic [7:0] cfg = `ISC_OFS_IRQ_CFG;
  localparam logic [7:0] lvl = `ISC_OFS_FIFO_INT;
  localparam logic [7:0] cnt = `ISC_OFS_GPT_CNT;
  localparam logic [7:0] bte = `ISC_OFS_BYTE_TEST;
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic        ce = 1'b1;
  logic [19:0] ev = '0;
  logic [7:0]  tx_used = '0;
  logic [7:0]  free_blk = '0;
  logic [7:0]  rx_used = '0;
  logic        psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  wire  [31:0] prdata;
  wire         pready, pslverr, irq_line, power_irq, wake_q, stop_tx_req;
  int          compares = 0;
  int          miscompares = 0;
  int          cyc = 0;

  // 100 MHz clock.
  always #5 clk_sys = ~clk_sys;

  isc_top i_dut (.clk_sys(clk_sys), .resetn(resetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_halted(ev[0]),
    .tx_buf_loaded_ioc(ev[1]), .tx_status_push(ev[2]),
    .tx_status_full(ev[3]), .tx_status_used(tx_used),
    .tx_data_free_blocks(free_blk), .tx_data_write(ev[4]),
    .tx_data_full(ev[5]), .tx_error(ev[6]), .rx_halted(ev[7]),
    .rx_data_pop(ev[8]), .rx_frame_dropped(ev[9]), .rx_byte(ev[10]),
    .rx_frame_end(ev[11]), .rx_status_full(ev[12]), .rx_error(ev[13]),
    .rx_status_used(rx_used), .timer_tick(ev[14]), .phy_event(ev[15]),
    .power_event(ev[16]), .io_line_events(ev[19:17]), .irq_line(irq_line),
    .power_irq(power_irq), .wake_q(wake_q), .stop_tx_req(stop_tx_req));
  isc_host i_host (.clk_sys(clk_sys), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready));

  // ==================
  // Shared tasks
  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] t;
    t = d;
    i_host.xfer(1'b1, a, t);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] t;
    t = 32'h0;
    i_host.xfer(1'b0, a, t);
    check(t, e);
  endtask
  // One cycle of the chosen source inputs.
  task pulse(input logic [19:0] m);
    @(posedge clk_sys);
    ev <= m;
    @(posedge clk_sys);
    ev <= '0;
  endtask

  // ==================
  // Scenarios
  task t_reset;
    rd(sts, 32'h0);
    rd(lvl, 32'h48000000);
    rd(cnt, 32'h0000FFFF);
    wr(8'h04, 32'hFFFFFFFF);
    rd(8'h04, 32'h0);
    check({31'h0, pslverr}, 32'h0);
  endtask
  // Twelve source patterns in turn, with the software flag held beside it.
  task t_sources;
    logic [51:0] tb [12];
    tb = '{{20'h00001, 32'h02000000},
      {20'h00002, 32'h00200000},
      {20'h0000C, 32'h00010100},
      {20'h00030, 32'h00000400},
      {20'h00010, 32'h00000000},
      {20'h00040, 32'h00002000},
      {20'h00080, 32'h01000000},
      {20'h00200, 32'h00000040},
      {20'h01000, 32'h00000010},
      {20'h02000, 32'h00004000},
      {20'h10000, 32'h00020000},
      {20'hE0000, 32'h00000007}};
    wr(`ISC_OFS_EVT_CTRL, 32'h1);
    wr(ena, 32'h80000000);
    check({31'h0, stop_tx_req}, 32'h1);
    rd(sts, 32'h80000000);
    foreach (tb[i]) begin
      pulse(tb[i][51:32]);
      rd(sts, tb[i][31:0] | 32'h80000000);
      wr(sts, 32'h0);
      rd(sts, tb[i][31:0] | 32'h80000000);
      wr(sts, tb[i][31:0]);
      rd(sts, 32'h80000000);
    end
    rd(`ISC_OFS_RX_DROP, 32'h00000001);
    wr(sts, 32'h80000000);
    rd(sts, 32'h0);
    wr(ena, 32'h0);
  endtask
  task t_levels;
    wr(lvl, 32'h05030002);
    free_blk <= 8'h05;
    tx_used <= 8'h03;
    rx_used <= 8'h02;
    rd(sts, 32'h0);
    free_blk <= 8'h06;
    tx_used <= 8'h04;
    rx_used <= 8'h03;
    rd(sts, 32'h00000288);
    wr(sts, 32'h00000288);
  endtask
  task t_counts;
    for (int n = 2048; n <= 2049; n++) begin
      ev[10] <= 1'b1;
      repeat (n) @(posedge clk_sys);
      ev[10] <= 1'b0;
      pulse(20'h00800);
      rd(sts, (n == 2049) ? 32'h00008000 : 32'h0);
    end
    wr(sts, 32'h00008000);
    wr(`ISC_OFS_RX_CFG, 32'h00020000);
    pulse(20'h00100);
    rd(sts, 32'h0);
    pulse(20'h00100);
    rd(sts, 32'h00100000);
    wr(sts, 32'h00100000);
    ev[14] <= 1'b1;
    repeat (65535) @(posedge clk_sys);
    ev[14] <= 1'b0;
    rd(cnt, 32'h0);
    pulse(20'h04000);
    rd(cnt, 32'h0000FFFF);
    rd(sts, 32'h00080000);
    wr(sts, 32'h00080000);
  endtask
  task t_irq;
    wr(ena, 32'h00020040);
    wr(cfg, 32'h00000100);
    pulse(20'h00200);
    #1;
    check({31'h0, irq_line}, 32'h1);
    check({31'h0, power_irq}, 32'h0);
    rd(cfg, 32'h00001100);
    pulse(20'h10000);
    ce <= 1'b0;
    #1;
    check({31'h0, power_irq}, 32'h1);
    wr(sts, 32'h00020040);
    ce <= 1'b1;
    rd(sts, 32'h00020040);
    wr(sts, 32'h00020040);
    #1;
    check({31'h0, irq_line}, 32'h0);
    wr(cfg, 32'h0);
    wr(bte, 32'h0);
    #1;
    check({31'h0, wake_q}, 32'h1);
    pulse(20'h10000);
    #1;
    check({31'h0, wake_q}, 32'h0);
    @(posedge clk_sys);
    ev[15] <= 1'b1;
    wr(sts, 32'h00060000);
    rd(sts, 32'h00040000);
    ev[15] <= 1'b0;
    rd(sts, 32'h0);
  endtask

  // Print the counts and the verdict, then stop.
  task final_report;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Cut a hung run short.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      miscompares++;
      final_report();
    end
  end

  // Main sequence.
  initial begin
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    t_reset();
    t_sources();
    t_levels();
    t_counts();
    t_irq();
    final_report();
  end
endmodule
`default_nettype wire
